// *** common/nal_pkg.sv ***
// Constants and types shared by the act bit and loopback 2 control block.
// Assumes a single 20 MHz clock domain and one 2B+D word (B1, B2, D) per frame.
//
// Overview of operation
// - TDM data output floats outside B and D bits, including the six spare D bits.
// - Act mode select is bit 6 of the global interface config word.
// - ANSI mode: loopback 2 request loops 2B+D back to the line at once.
// - ANSI mode: upstream act bit is sent as 0 while loopback 2 holds.
// - Outside loopback 2, upstream data passes only after downstream act is 1.
// - ANSI mode: upstream transparency starts at the loopback 2 command, ignoring act.
// - ETSI mode: upstream act bit follows INFO 3 detection only, also in loopback 2.
// - Loopback 2 loops S/T transmit to receiver; self sync then reports INFO 3.
// - ETSI mode loopback 2: pass looped data if act is 1, else all ones.
package nal_pkg;

   // Clock and timing.
   localparam int CLK_HZ = 20_000_000;
   localparam int SELF_SYNC_US = 250;
   localparam int SELF_SYNC_CYCLES = SELF_SYNC_US * (CLK_HZ / 1_000_000);
   localparam int TDM_BIT_CYCLES = 4;

   // Global interface config word.
   localparam int GIC_WIDTH = 8;
   localparam int ACT_SEL_BIT = 6;
   localparam logic ACT_SEL_ETSI = 1'b1;
   localparam logic [GIC_WIDTH-1:0] GIC_RESET = 8'h00;

   // Frame layout: B1 in bits 17:10, B2 in bits 9:2, D in bits 1:0.
   localparam int B_BITS = 8;
   localparam int D_BITS = 2;
   localparam int D_SPARE_BITS = 6;
   localparam int WORD_BITS = 2 * B_BITS + D_BITS;
   localparam int TDM_SLOT_BITS = 2 * B_BITS + D_BITS + D_SPARE_BITS;
   localparam logic [WORD_BITS-1:0] WORD_RESET = 18'h0_0000;

   // Upstream buffer.
   localparam int FIFO_DEPTH = 16;

   typedef enum logic [1:0] {
      LB_OFF,
      LB_SYNC,
      LB_ON
   } nal_loop_state_type;

   typedef enum logic {
      TDM_IDLE,
      TDM_SHIFT
   } nal_tdm_state_type;

endpackage : nal_pkg

// *** rtl/nal_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides, storage in flip-flops.
// Assumes both sides run on the same clock; a write into a full FIFO is refused.
`timescale 1ns/100ps
module nal_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      if (p == AW'(DEPTH - 1)) begin
         return '0;
      end
      return p + 1'b1;
   endfunction : ptr_inc

   assign in_ready = (cnt_q != (AW + 1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = in_data;
         wr_d = ptr_inc(wr_q);
      end
      if (pop) begin
         rd_d = ptr_inc(rd_q);
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         mem_q <= mem_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

endmodule : nal_fifo

// *** rtl/nal_loop_ctrl.sv ***
// Act bit, loopback 2 and upstream transparency control of a network termination.
// Assumes eoc decoding, U framing and the S/T receiver are separate logic on mclk;
// the INFO 3 indication and the TDM frame strobe arrive from outside and are synchronised.
`timescale 1ns/100ps
module nal_loop_ctrl #(
   parameter int SYNC_CYCLES = nal_pkg::SELF_SYNC_CYCLES,
   parameter int FIFO_DEPTH = nal_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Configuration
   input wire logic [nal_pkg::GIC_WIDTH-1:0] global_interface_config,
   // Embedded operations channel commands
   input wire logic lb2_request,
   input wire logic lb2_release,
   // Act bits on the U-interface
   input wire logic act_down,
   output logic act_up,
   // S/T-interface status and control
   input wire logic info3_detect,
   output logic st_loop_enable,
   output logic lb2_active,
   // Upstream data from the S/T side
   input wire logic st_rx_valid,
   output logic st_rx_ready,
   input wire logic [nal_pkg::WORD_BITS-1:0] st_rx_data,
   // Downstream data from the U side
   input wire logic u_rx_valid,
   output logic u_rx_ready,
   input wire logic [nal_pkg::WORD_BITS-1:0] u_rx_data,
   // Upstream data toward the U side
   output logic u_tx_valid,
   input wire logic u_tx_ready,
   output logic [nal_pkg::WORD_BITS-1:0] u_tx_data,
   // TDM bus
   input wire logic tdm_frame_sync,
   output logic tdm_data_out,
   output logic tdm_data_oe
);

   localparam int WB = nal_pkg::WORD_BITS;
   localparam int SCW = $clog2(SYNC_CYCLES + 1);
   localparam logic [WB-1:0] ALL_ONES = {WB{1'b1}};

   // ------------------------------------------------------------------
   // Input synchronisers.
   // ------------------------------------------------------------------
   logic info3_meta_q, info3_meta_d;
   logic info3_sync_q, info3_sync_d;
   logic fs_meta_q, fs_meta_d;
   logic fs_sync_q, fs_sync_d;
   logic fs_prev_q, fs_prev_d;

   always_comb begin
      info3_meta_d = info3_detect;
      info3_sync_d = info3_meta_q;
      fs_meta_d = tdm_frame_sync;
      fs_sync_d = fs_meta_q;
      fs_prev_d = fs_sync_q;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         info3_meta_q <= 1'b0;
         info3_sync_q <= 1'b0;
         fs_meta_q <= 1'b0;
         fs_sync_q <= 1'b0;
         fs_prev_q <= 1'b0;
      end else begin
         info3_meta_q <= info3_meta_d;
         info3_sync_q <= info3_sync_d;
         fs_meta_q <= fs_meta_d;
         fs_sync_q <= fs_sync_d;
         fs_prev_q <= fs_prev_d;
      end
   end

   // ------------------------------------------------------------------
   // Mode select and loopback 2 state.
   // ------------------------------------------------------------------
   logic etsi_mode;
   nal_pkg::nal_loop_state_type lb_q, lb_d;
   logic [SCW-1:0] sync_cnt_q, sync_cnt_d;

   assign etsi_mode = (global_interface_config[nal_pkg::ACT_SEL_BIT] == nal_pkg::ACT_SEL_ETSI);

   // The S/T transmitter is looped to its own receiver; after the self sync time the
   // receiver reports INFO 3 whether or not a terminal is attached.
   always_comb begin
      lb_d = lb_q;
      sync_cnt_d = sync_cnt_q;
      unique case (lb_q)
         nal_pkg::LB_OFF: begin
            if (lb2_request) begin
               lb_d = nal_pkg::LB_SYNC;
               sync_cnt_d = '0;
            end
         end
         nal_pkg::LB_SYNC: begin
            if (lb2_release) begin
               lb_d = nal_pkg::LB_OFF;
            end else if (sync_cnt_q == SCW'(SYNC_CYCLES - 1)) begin
               lb_d = nal_pkg::LB_ON;
            end else begin
               sync_cnt_d = sync_cnt_q + 1'b1;
            end
         end
         nal_pkg::LB_ON: begin
            if (lb2_release) begin
               lb_d = nal_pkg::LB_OFF;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         lb_q <= nal_pkg::LB_OFF;
         sync_cnt_q <= '0;
      end else begin
         lb_q <= lb_d;
         sync_cnt_q <= sync_cnt_d;
      end
   end

   assign lb2_active = (lb_q != nal_pkg::LB_OFF);
   assign st_loop_enable = lb2_active;

   // ------------------------------------------------------------------
   // Upstream act bit.
   // ------------------------------------------------------------------
   logic info3_seen;
   logic act_up_q, act_up_d;

   always_comb begin
      if (lb2_active) begin
         info3_seen = (lb_q == nal_pkg::LB_ON);
      end else begin
         info3_seen = info3_sync_q;
      end
      if (!etsi_mode && lb2_active) begin
         act_up_d = 1'b0;
      end else begin
         act_up_d = info3_seen;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         act_up_q <= 1'b0;
      end else begin
         act_up_q <= act_up_d;
      end
   end

   assign act_up = act_up_q;

   // ------------------------------------------------------------------
   // Upstream data selection into the buffer. During loopback 2 the
   // downstream words are the source; otherwise the S/T words are.
   // The line termination raises downstream act only after our act is 1,
   // so in ETSI loopback 2 the looped data stays all ones until then.
   // ------------------------------------------------------------------
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [WB-1:0] fifo_in_data;
   logic u_rx_take;

   always_comb begin
      if (lb2_active) begin
         fifo_in_valid = u_rx_valid;
         if (!etsi_mode) begin
            fifo_in_data = u_rx_data;
         end else if (act_down) begin
            fifo_in_data = u_rx_data;
         end else begin
            fifo_in_data = ALL_ONES;
         end
      end else begin
         fifo_in_valid = st_rx_valid;
         if (act_down) begin
            fifo_in_data = st_rx_data;
         end else begin
            fifo_in_data = ALL_ONES;
         end
      end
   end

   // Downstream words are only held back while they feed the loop.
   assign st_rx_ready = !lb2_active && fifo_in_ready;
   assign u_rx_ready = lb2_active ? fifo_in_ready : 1'b1;
   assign u_rx_take = u_rx_valid && u_rx_ready;

   nal_fifo #(
      .WIDTH(WB),
      .DEPTH(FIFO_DEPTH)
   ) u_up_fifo (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(u_tx_valid),
      .out_ready(u_tx_ready),
      .out_data(u_tx_data)
   );

   // ------------------------------------------------------------------
   // TDM bus: the latest downstream 2B+D word is shifted out after each
   // frame strobe, MSB first: B1, B2, then the two D bits. The six spare
   // bits of the D octet and the rest of the frame are left floating.
   // ------------------------------------------------------------------
   localparam int BIW = $clog2(nal_pkg::TDM_SLOT_BITS + 1);
   localparam int CCW = $clog2(nal_pkg::TDM_BIT_CYCLES + 1);

   nal_pkg::nal_tdm_state_type tdm_q, tdm_d;
   logic [WB-1:0] tdm_word_q, tdm_word_d;
   logic [WB-1:0] tdm_shift_q, tdm_shift_d;
   logic [BIW-1:0] bit_idx_q, bit_idx_d;
   logic [CCW-1:0] bit_cyc_q, bit_cyc_d;
   logic dout_q, dout_d;
   logic doe_q, doe_d;
   logic fs_rise;

   assign fs_rise = fs_sync_q && !fs_prev_q;

   always_comb begin
      tdm_d = tdm_q;
      tdm_word_d = tdm_word_q;
      tdm_shift_d = tdm_shift_q;
      bit_idx_d = bit_idx_q;
      bit_cyc_d = bit_cyc_q;
      dout_d = dout_q;
      doe_d = 1'b0;
      if (u_rx_take) begin
         tdm_word_d = u_rx_data;
      end
      unique case (tdm_q)
         nal_pkg::TDM_IDLE: begin
            if (fs_rise) begin
               tdm_d = nal_pkg::TDM_SHIFT;
               tdm_shift_d = tdm_word_q;
               bit_idx_d = '0;
               bit_cyc_d = '0;
            end
         end
         nal_pkg::TDM_SHIFT: begin
            if (bit_idx_q < BIW'(WB)) begin
               doe_d = 1'b1;
               dout_d = tdm_shift_q[WB-1];
            end else begin
               dout_d = 1'b0;
            end
            if (bit_cyc_q == CCW'(nal_pkg::TDM_BIT_CYCLES - 1)) begin
               bit_cyc_d = '0;
               tdm_shift_d = {tdm_shift_q[WB-2:0], 1'b0};
               if (bit_idx_q == BIW'(nal_pkg::TDM_SLOT_BITS - 1)) begin
                  tdm_d = nal_pkg::TDM_IDLE;
               end else begin
                  bit_idx_d = bit_idx_q + 1'b1;
               end
            end else begin
               bit_cyc_d = bit_cyc_q + 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tdm_q <= nal_pkg::TDM_IDLE;
         tdm_word_q <= nal_pkg::WORD_RESET;
         tdm_shift_q <= nal_pkg::WORD_RESET;
         bit_idx_q <= '0;
         bit_cyc_q <= '0;
         dout_q <= 1'b0;
         doe_q <= 1'b0;
      end else begin
         tdm_q <= tdm_d;
         tdm_word_q <= tdm_word_d;
         tdm_shift_q <= tdm_shift_d;
         bit_idx_q <= bit_idx_d;
         bit_cyc_q <= bit_cyc_d;
         dout_q <= dout_d;
         doe_q <= doe_d;
      end
   end

   assign tdm_data_out = dout_q;
   assign tdm_data_oe = doe_q;

endmodule : nal_loop_ctrl

// *** dv/nal_loop_ctrl_assertions.sv ***
// Concurrent checks on the loopback, act bit, data gate and TDM enable ports.
// Bound to nal_loop_ctrl from the bench top file; sees only its ports.
`timescale 1ns/100ps
module nal_loop_ctrl_assertions #(
   parameter int SYNC_CYCLES = 8
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Control
   input wire logic [nal_pkg::GIC_WIDTH-1:0] global_interface_config,
   input wire logic lb2_request,
   input wire logic lb2_release,
   input wire logic act_down,
   input wire logic act_up,
   input wire logic lb2_active,
   input wire logic st_loop_enable,
   // Data
   input wire logic st_rx_valid,
   input wire logic st_rx_ready,
   input wire logic u_rx_valid,
   input wire logic u_rx_ready,
   input wire logic [nal_pkg::WORD_BITS-1:0] u_rx_data,
   input wire logic u_tx_valid,
   input wire logic [nal_pkg::WORD_BITS-1:0] u_tx_data,
   input wire logic tdm_data_oe
);
   localparam int SYNC_MAX = SYNC_CYCLES + 4;
   wire logic etsi = global_interface_config[nal_pkg::ACT_SEL_BIT] == nal_pkg::ACT_SEL_ETSI;
   wire logic u_push = u_rx_valid && u_rx_ready && lb2_active && !u_tx_valid;

   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);

   property p_lb_enter; lb2_request && !lb2_active |=> lb2_active && st_loop_enable; endproperty
   a_lb_enter: assert property (p_lb_enter)
      else $error("loopback not entered");
   property p_lb_exit; lb2_release && lb2_active |=> !lb2_active && !st_loop_enable; endproperty
   a_lb_exit: assert property (p_lb_exit)
      else $error("loopback not left");
   property p_ansi_act; lb2_active && !etsi |=> !act_up; endproperty
   a_ansi_act: assert property (p_ansi_act)
      else $error("act sent in loop");
   property p_etsi_act; $rose(lb2_active) && etsi |-> ##[1:SYNC_MAX] act_up; endproperty
   a_etsi_act: assert property (p_etsi_act)
      else $error("no self sync act");
   property p_gate_up;
      !lb2_active && !act_down && st_rx_valid && st_rx_ready && !u_tx_valid |=> u_tx_valid && &u_tx_data;
   endproperty
   a_gate_up: assert property (p_gate_up)
      else $error("data not gated");
   property p_ansi_pass; u_push && !etsi |=> u_tx_valid && u_tx_data == $past(u_rx_data); endproperty
   a_ansi_pass: assert property (p_ansi_pass)
      else $error("loop data lost");
   property p_etsi_ones; u_push && etsi && !act_down |=> u_tx_valid && &u_tx_data; endproperty
   a_etsi_ones: assert property (p_etsi_ones)
      else $error("loop data not ones");
   property p_oe_hold; $rose(tdm_data_oe) |-> tdm_data_oe[*8]; endproperty
   a_oe_hold: assert property (p_oe_hold)
      else $error("tdm enable short");
   property p_oe_gap; $fell(tdm_data_oe) |-> !tdm_data_oe[*8]; endproperty
   a_oe_gap: assert property (p_oe_gap)
      else $error("tdm spare driven");
endmodule : nal_loop_ctrl_assertions

// *** dv/nal_lt_model.sv ***
// Line termination model: returns act downstream and drains upstream words.
// Assumes the bench permits act and commands stalls.
`timescale 1ns/100ps
module nal_lt_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Bench control
   input wire logic allow_act,
   input wire logic stall,
   // U side
   input wire logic act_up,
   output logic act_down,
   output logic u_tx_ready
);
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         act_down <= 1'b0;
      end else begin
         act_down <= allow_act && (act_down || act_up);
      end
   end
   assign u_tx_ready = !stall;
endmodule : nal_lt_model

// *** dv/tb.sv ***
// Self-checking bench for nal_loop_ctrl with a line termination model.
// Assumes the short self sync count of 8 cycles.
`timescale 1ns/100ps
module tb;
   logic mclk, sys_rst, lb2_request, lb2_release, act_down, act_up, info3_detect;
   logic st_loop_enable, lb2_active, st_rx_valid, st_rx_ready, u_rx_valid, u_rx_ready;
   logic u_tx_valid, u_tx_ready, tdm_frame_sync, tdm_data_out, tdm_data_oe, allow_act, stall;
   logic [7:0] global_interface_config;
   logic [17:0] st_rx_data, u_rx_data, u_tx_data, w, d;
   logic [21:0] rows [5];
   int errors, tests_run, cyc;

   nal_loop_ctrl #(.SYNC_CYCLES(8)) i_dut (.mclk, .sys_rst, .global_interface_config, .lb2_request,
      .lb2_release, .act_down, .act_up, .info3_detect, .st_loop_enable, .lb2_active, .st_rx_valid,
      .st_rx_ready, .st_rx_data, .u_rx_valid, .u_rx_ready, .u_rx_data, .u_tx_valid, .u_tx_ready,
      .u_tx_data, .tdm_frame_sync, .tdm_data_out, .tdm_data_oe);
   nal_lt_model i_lt (.mclk, .sys_rst, .allow_act, .stall, .act_up, .act_down, .u_tx_ready);

   task test_done;
      if (errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done

   task chk(input string n, input logic [17:0] e, input logic [17:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask : chk

   task pulse(input bit rel);
      @(posedge mclk);
      if (rel) lb2_release <= 1'b1;
      else lb2_request <= 1'b1;
      @(posedge mclk);
      lb2_release <= 1'b0;
      lb2_request <= 1'b0;
   endtask : pulse

   task push(input logic [17:0] v);
      int n;
      n = 0;
      @(posedge mclk);
      {st_rx_valid, u_rx_valid, st_rx_data, u_rx_data} <= {2'b11, v, v};
      @(negedge mclk);
      while (!(lb2_active ? u_rx_ready : st_rx_ready) && n < 100) begin
         @(negedge mclk);
         n++;
      end
      chk("src_ready", 1, lb2_active ? u_rx_ready : st_rx_ready);
      @(posedge mclk);
      {st_rx_valid, u_rx_valid} <= 2'b00;
   endtask : push

   task get(output logic [17:0] v);
      int n;
      n = 0;
      @(negedge mclk);
      while (!(u_tx_valid && u_tx_ready) && n < 100) begin
         @(negedge mclk);
         n++;
      end
      chk("u_tx_valid", 1, u_tx_valid);
      v = u_tx_data;
      @(posedge mclk);
   endtask : get

   initial begin
      mclk = 0;
      forever #25 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         test_done;
      end
   end

   initial begin
      // Columns: ETSI mode, loop, act allowed, ones expected, word.
      rows = '{{4'b0001, 18'h2_a5c3}, {4'b0010, 18'h1_5a3c}, {4'b0100, 18'h0_f0f0},
         {4'b1101, 18'h3_0f0e}, {4'b1110, 18'h2_3456}};
      {sys_rst, lb2_request, lb2_release, info3_detect, st_rx_valid, u_rx_valid} = 6'h20;
      {tdm_frame_sync, allow_act, stall, st_rx_data, u_rx_data} = '0;
      global_interface_config = 8'h00;
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      @(negedge mclk);
      chk("act_up", 0, act_up);
      chk("tdm_oe", 0, tdm_data_oe);
      chk("st_rx_ready", 1, st_rx_ready);
      chk("u_rx_ready", 1, u_rx_ready);
      chk("u_tx_valid", 0, u_tx_valid);
      foreach (rows[i]) begin
         @(posedge mclk);
         global_interface_config <= rows[i][21] ? 8'h40 : 8'h00;
         allow_act <= rows[i][19];
         info3_detect <= !rows[i][20];
         if (rows[i][20]) pulse(0);
         repeat (30) @(posedge mclk);
         @(negedge mclk);
         chk("act_up", !(rows[i][20] && !rows[i][21]), act_up);
         push(rows[i][17:0]);
         get(d);
         chk("word", rows[i][18] ? 18'h3_ffff : rows[i][17:0], d);
         if (rows[i][20]) pulse(1);
      end
      // Fill the buffer with the far side stalled, then drain it in order.
      @(posedge mclk);
      {global_interface_config, allow_act, info3_detect, stall} <= {8'h00, 3'b111};
      repeat (30) @(posedge mclk);
      for (int i = 0; i < 16; i++) push({3{i[5:0]}});
      @(negedge mclk);
      chk("st_rx_ready", 0, st_rx_ready);
      @(posedge mclk);
      stall <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         get(d);
         chk("fifo", {3{i[5:0]}}, d);
      end
      w = {3{6'h0f}};
      @(posedge mclk);
      tdm_frame_sync <= 1'b1;
      repeat (2) @(posedge mclk);
      tdm_frame_sync <= 1'b0;
      for (int n = 0; n < 20 && tdm_data_oe !== 1'b1; n++) @(negedge mclk);
      for (int i = 0; i < 96; i++) begin
         chk("tdm_oe", i < 72, tdm_data_oe);
         if (i < 72) chk("tdm_bit", w[17 - i / 4], tdm_data_out);
         @(negedge mclk);
      end
      @(posedge mclk);
      info3_detect <= 1'b0;
      repeat (10) @(negedge mclk);
      chk("act_up", 0, act_up);
      pulse(0);
      @(negedge mclk);
      chk("lb2_active", 1, lb2_active);
      @(posedge mclk);
      sys_rst <= 1'b1;
      @(negedge mclk);
      chk("lb2_active", 0, lb2_active);
      chk("st_loop", 0, st_loop_enable);
      @(posedge mclk);
      sys_rst <= 1'b0;
      @(negedge mclk);
      chk("act_up", 0, act_up);
      chk("u_tx_valid", 0, u_tx_valid);
      chk("u_rx_ready", 1, u_rx_ready);
      chk("tdm_oe", 0, tdm_data_oe);
      @(negedge mclk);
      chk("lb2_active", 0, lb2_active);
      chk("st_rx_ready", 1, st_rx_ready);
      test_done;
   end
endmodule : tb

bind nal_loop_ctrl nal_loop_ctrl_assertions #(.SYNC_CYCLES(SYNC_CYCLES)) i_chk (.mclk, .sys_rst,
   .global_interface_config, .lb2_request, .lb2_release, .act_down, .act_up, .lb2_active,
   .st_loop_enable, .st_rx_valid, .st_rx_ready, .u_rx_valid, .u_rx_ready, .u_rx_data, .u_tx_valid,
   .u_tx_data, .tdm_data_oe);
